// ==== hdl/gdp_pin_interface.sv ====
// Device side pin interface: command capture, power states, bank tracking and data bursts.
`timescale 1ns/1ps
// Operation
// - capture commands on rising clock crossing only
// - read beats on both clock crossings
// - clock enable gates clocks, buffers, drivers
// - idle banks give precharge pdn, else active
// - clock enable sampled on edges for pdn
// - self refresh exit without clock edge
// - power-down keeps only clock and enable buffers
// - self refresh keeps only enable buffer
// - chip select high masks the command
// - decode command from strobes and select
// - masked write beats are not stored
// - bank select picks the bank
// - row, column and auto precharge from address
// - address bit eight selects all-bank precharge
// - mode set loads address as opcode
// - read strobe toggles with each data beat
// - mirror low leaves reserved receiver unused
// - mirror high moves row strobe to reserved ball
// - mirror select input remaps ball functions
module gdp_pin_interface
	import gdp_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              rst_n,
	input  wire logic              ckTrue,
	input  wire logic              ckComp,
	input  wire logic              clockEnable,
	input  wire gdp_cmd_pins_t     cmdPins,
	input  wire logic              mirrorReserved,
	input  wire logic              mirrorSelect,
	input  wire logic [LANES-1:0]  writeMask,
	input  wire logic [LANES-1:0]  writeStrobe,
	input  wire logic [DATA_W-1:0] dataIn,
	output logic      [DATA_W-1:0] dataOut,
	output logic                   dataOe,
	output logic      [LANES-1:0]  readStrobe,
	output logic                   readStrobeOe,
	output logic      [ROW_W-1:0]  modeReg,
	output gdp_pwr_t               powerState
);
	localparam int SYNC_W = 2 + 1 + $bits(gdp_cmd_pins_t) + 2 + 2 * LANES + DATA_W;

	////////////////////////////////////////////////////////////////////////////////
	// Every pin is asynchronous to clk, so all of them pass the synchroniser.
	logic [SYNC_W-1:0] syncVec;
	logic              ckTrueS;
	logic              ckCompS;
	logic              ckeS;
	gdp_cmd_pins_t     cmdS;
	logic              mirrorResS;
	logic              mirrorSelS;
	logic [LANES-1:0]  maskS;
	logic [LANES-1:0]  wStrobeS;
	logic [DATA_W-1:0] dataS;

	gdp_sync #(.W(SYNC_W)) u_sync (
		.clk     (clk),
		.rst_n   (rst_n),
		.asyncIn ({ckTrue, ckComp, clockEnable, cmdPins, mirrorReserved, mirrorSelect,
			writeMask, writeStrobe, dataIn}),
		.syncOut (syncVec)
	);

	assign {ckTrueS, ckCompS, ckeS, cmdS, mirrorResS, mirrorSelS, maskS, wStrobeS, dataS} = syncVec;

	////////////////////////////////////////////////////////////////////////////////
	// Clock crossing detection and input buffer gating.
	gdp_pwr_t          power_ff;
	gdp_pwr_t          nxt_power;
	logic              crossHigh_ff;
	logic              crossHigh;
	logic              clkBufOn;
	logic              cmdBufOn;
	logic              rise;
	logic              fall;
	logic              mirror_ff;
	logic              nxt_mirror;

	assign crossHigh = ckTrueS & ~ckCompS;
	assign clkBufOn  = (power_ff != PWR_SELF_REF);
	assign cmdBufOn  = (power_ff == PWR_ACTIVE);
	assign rise      = clkBufOn & crossHigh & ~crossHigh_ff;
	assign fall      = clkBufOn & ~crossHigh & crossHigh_ff & ~ckTrueS & ckCompS;

	////////////////////////////////////////////////////////////////////////////////
	// Command decode at the rising crossing.
	logic              rowStrobeN;
	gdp_cmd_t          cmd;
	logic [COL_W-1:0]  column;

	// The mirror strap picks which ball carries the row strobe; the other receiver is ignored.
	assign rowStrobeN = mirror_ff ? mirrorResS : cmdS.rowStrobeN;
	assign column     = {cmdS.addr[COL_HI_BIT], cmdS.addr[AP_BIT-1:0]};

	always_comb begin
		cmd = CMD_NOP;
		if (cmdS.chipSelectN) begin
			cmd = CMD_DESELECT;
		end else begin
			unique case ({rowStrobeN, cmdS.columnStrobeN, cmdS.writeEnableN})
				CODE_MODE:  cmd = CMD_MODE_SET;
				CODE_REF:   cmd = CMD_REFRESH;
				CODE_PRE:   cmd = CMD_PRECHARGE;
				CODE_ACT:   cmd = CMD_ACTIVATE;
				CODE_WRITE: cmd = CMD_WRITE;
				CODE_READ:  cmd = CMD_READ;
				default:    cmd = CMD_NOP;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Power state, banks, mode register and read burst.
	logic [BANKS-1:0]     rowOpen_ff;
	logic [BANKS-1:0]     nxt_rowOpen;
	logic [ROW_W-1:0]     openRow_ff [BANKS];
	logic [ROW_W-1:0]     nxt_openRow [BANKS];
	logic [ROW_W-1:0]     modeReg_ff;
	logic [ROW_W-1:0]     nxt_modeReg;
	logic [2:0]           rdLeft_ff;
	logic [2:0]           nxt_rdLeft;
	logic [1:0]           rdBank_ff;
	logic [1:0]           nxt_rdBank;
	logic [MEM_COL_W-1:0] rdCol_ff;
	logic [MEM_COL_W-1:0] nxt_rdCol;
	logic [DATA_W-1:0]    dataOut_ff;
	logic [DATA_W-1:0]    nxt_dataOut;
	logic                 dataOe_ff;
	logic                 nxt_dataOe;
	logic [LANES-1:0]     readStrobe_ff;
	logic [LANES-1:0]     nxt_readStrobe;
	logic [DATA_W-1:0]    mem [MEM_DEPTH];
	logic                 cmdTaken;
	logic                 beatFire;

	assign cmdTaken = rise & cmdBufOn & ckeS;
	assign beatFire = (rise | fall) & ckeS & (rdLeft_ff != BEATS_NONE) & cmdBufOn;

	always_comb begin
		nxt_power      = power_ff;
		nxt_rowOpen    = rowOpen_ff;
		nxt_openRow    = openRow_ff;
		nxt_modeReg    = modeReg_ff;
		nxt_rdLeft     = rdLeft_ff;
		nxt_rdBank     = rdBank_ff;
		nxt_rdCol      = rdCol_ff;
		nxt_dataOut    = dataOut_ff;
		nxt_dataOe     = dataOe_ff;
		nxt_readStrobe = readStrobe_ff;
		// The strap is tied on the board, so it is followed all the time; catching it only once would see
		// the synchroniser still holding its reset value.
		nxt_mirror     = mirrorSelS;
		unique case (power_ff)
			PWR_ACTIVE: begin
				if (rise && !ckeS) begin
					if (rowOpen_ff != '0) begin
						nxt_power = PWR_ACT_PDN;
					end else if (cmd == CMD_REFRESH) begin
						nxt_power = PWR_SELF_REF;
					end else begin
						nxt_power = PWR_PRE_PDN;
					end
				end
			end
			PWR_PRE_PDN, PWR_ACT_PDN: begin
				if (rise && ckeS) begin
					nxt_power = PWR_ACTIVE;
				end
			end
			PWR_SELF_REF: begin
				if (ckeS) begin
					nxt_power = PWR_ACTIVE;
				end
			end
		endcase
		// Losing the enable mid-burst drops the drivers at once; the burst is abandoned.
		if (!ckeS || !cmdBufOn) begin
			nxt_dataOe = 1'b0;
			nxt_rdLeft = BEATS_NONE;
		end else if (beatFire) begin
			nxt_dataOut    = mem[{rdBank_ff, rdCol_ff}];
			nxt_dataOe     = 1'b1;
			nxt_readStrobe = ~readStrobe_ff;
			nxt_rdLeft     = rdLeft_ff - 3'h1;
			nxt_rdCol      = rdCol_ff + 4'h1;
		end else if ((rise | fall) && rdLeft_ff == BEATS_NONE) begin
			nxt_dataOe = 1'b0;
		end
		if (cmdTaken) begin
			unique case (cmd)
				CMD_ACTIVATE: begin
					nxt_rowOpen[cmdS.bankSelect] = 1'b1;
					nxt_openRow[cmdS.bankSelect] = cmdS.addr;
				end
				CMD_READ, CMD_WRITE: begin
					if (cmd == CMD_READ) begin
						nxt_rdLeft = BURST_LEN;
						nxt_rdBank = cmdS.bankSelect;
						nxt_rdCol  = column[MEM_COL_W-1:0];
					end
					if (cmdS.addr[AP_BIT]) begin
						nxt_rowOpen[cmdS.bankSelect] = 1'b0;
					end
				end
				CMD_PRECHARGE: begin
					if (cmdS.addr[AP_BIT]) begin
						nxt_rowOpen = '0;
					end else begin
						nxt_rowOpen[cmdS.bankSelect] = 1'b0;
					end
				end
				CMD_MODE_SET: nxt_modeReg = cmdS.addr;
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			power_ff      <= PWR_ACTIVE;
			crossHigh_ff  <= 1'b0;
			rowOpen_ff    <= '0;
			openRow_ff    <= '{default: '0};
			modeReg_ff    <= '0;
			rdLeft_ff     <= BEATS_NONE;
			rdBank_ff     <= '0;
			rdCol_ff      <= '0;
			dataOut_ff    <= '0;
			dataOe_ff     <= 1'b0;
			readStrobe_ff <= '0;
			mirror_ff     <= 1'b0;
		end else begin
			power_ff      <= nxt_power;
			crossHigh_ff  <= crossHigh;
			rowOpen_ff    <= nxt_rowOpen;
			openRow_ff    <= nxt_openRow;
			modeReg_ff    <= nxt_modeReg;
			rdLeft_ff     <= nxt_rdLeft;
			rdBank_ff     <= nxt_rdBank;
			rdCol_ff      <= nxt_rdCol;
			dataOut_ff    <= nxt_dataOut;
			dataOe_ff     <= nxt_dataOe;
			readStrobe_ff <= nxt_readStrobe;
			mirror_ff     <= nxt_mirror;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Write capture: each byte lane counts its own strobe edges.
	logic [2:0]           wrLeft_ff [LANES];
	logic [2:0]           nxt_wrLeft [LANES];
	logic [MEM_COL_W-1:0] wrCol_ff [LANES];
	logic [MEM_COL_W-1:0] nxt_wrCol [LANES];
	logic [1:0]           wrBank_ff;
	logic [1:0]           nxt_wrBank;
	logic [LANES-1:0]     wsPrev_ff;
	logic [LANES-1:0]     wsEdge;
	logic [LANES-1:0]     wrStore;

	assign wsEdge = wStrobeS ^ wsPrev_ff;

	always_comb begin
		nxt_wrBank = wrBank_ff;
		for (int l = 0; l < LANES; l++) begin
			nxt_wrLeft[l] = wrLeft_ff[l];
			nxt_wrCol[l]  = wrCol_ff[l];
			wrStore[l]    = 1'b0;
			if (cmdTaken && cmd == CMD_WRITE) begin
				nxt_wrLeft[l] = BURST_LEN;
				nxt_wrCol[l]  = column[MEM_COL_W-1:0];
			end else if (!ckeS) begin
				nxt_wrLeft[l] = BEATS_NONE;
			end else if (wsEdge[l] && wrLeft_ff[l] != BEATS_NONE) begin
				wrStore[l]    = ~maskS[l];
				nxt_wrLeft[l] = wrLeft_ff[l] - 3'h1;
				nxt_wrCol[l]  = wrCol_ff[l] + 4'h1;
			end
		end
		if (cmdTaken && cmd == CMD_WRITE) begin
			nxt_wrBank = cmdS.bankSelect;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wrLeft_ff <= '{default: BEATS_NONE};
			wrCol_ff  <= '{default: '0};
			wrBank_ff <= '0;
			wsPrev_ff <= '0;
		end else begin
			wrLeft_ff <= nxt_wrLeft;
			wrCol_ff  <= nxt_wrCol;
			wrBank_ff <= nxt_wrBank;
			wsPrev_ff <= wStrobeS;
		end
	end

	// The array has no reset; its contents are undefined until written.
	always_ff @(posedge clk) begin
		for (int l = 0; l < LANES; l++) begin
			if (wrStore[l]) begin
				mem[{wrBank_ff, wrCol_ff[l]}][8*l +: 8] <= dataS[8*l +: 8];
			end
		end
	end

	assign dataOut      = dataOut_ff;
	assign dataOe       = dataOe_ff;
	assign readStrobe   = readStrobe_ff;
	assign readStrobeOe = dataOe_ff;
	assign modeReg      = modeReg_ff;
	assign powerState   = power_ff;

	////////////////////////////////////////////////////////////////////////////////
	// Checks.
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence selfRefIdle;
		power_ff == PWR_SELF_REF && !ckeS;
	endsequence
	sequence ckeReturns;
		power_ff == PWR_SELF_REF && ckeS;
	endsequence

	cross_only_a: assert property (cmdTaken |-> crossHigh && !crossHigh_ff)
		else $error("command taken off the rising crossing");
	beat_edge_a: assert property (beatFire |=> dataOe_ff && dataOut_ff == mem[$past({rdBank_ff, rdCol_ff})])
		else $error("read beat not driven");
	oe_gated_a: assert property (!ckeS |=> !dataOe_ff)
		else $error("drivers on with clock enable low");
	pdn_entry_a: assert property (power_ff == PWR_ACTIVE && rise && !ckeS && rowOpen_ff != '0
		|=> power_ff == PWR_ACT_PDN)
		else $error("wrong power-down state");
	sref_exit_a: assert property (selfRefIdle ##1 ckeReturns |=> power_ff == PWR_ACTIVE)
		else $error("self refresh exit missed");
	deselect_ignored_a: assert property (rise && cmdS.chipSelectN |=> $stable(modeReg_ff) && $stable(rowOpen_ff))
		else $error("deselected command acted on");
	mode_load_a: assert property (cmdTaken && cmd == CMD_MODE_SET |=> modeReg_ff == $past(cmdS.addr))
		else $error("mode register not loaded");
	pre_all_a: assert property (cmdTaken && cmd == CMD_PRECHARGE && cmdS.addr[AP_BIT] |=> rowOpen_ff == '0)
		else $error("all-bank precharge incomplete");
	strobe_toggle_a: assert property (beatFire |=> readStrobe_ff == ~$past(readStrobe_ff))
		else $error("read strobe not aligned with beat");
	masked_beat_a: assert property (wsEdge[0] && maskS[0] |-> !wrStore[0])
		else $error("masked beat stored");
	pdn_exit_a: assert property ((power_ff == PWR_PRE_PDN || power_ff == PWR_ACT_PDN) && rise && ckeS
		|=> power_ff == PWR_ACTIVE)
		else $error("power-down exit missed");
	row_latch_a: assert property (cmdTaken && cmd == CMD_ACTIVATE
		|=> rowOpen_ff[$past(cmdS.bankSelect)] && openRow_ff[$past(cmdS.bankSelect)] == $past(cmdS.addr))
		else $error("activated row not latched");
endmodule

// ==== hdl/gdp_pkg.sv ====
// Shared constants, pin groups and state types for the graphics DRAM pin interface.
package gdp_pkg;

	localparam int          BANKS       = 4;
	localparam int          LANES       = 4;
	localparam int          DATA_W      = 32;
	localparam int          ROW_W       = 12;
	localparam int          COL_W       = 9;
	localparam int          MEM_COL_W   = 4;
	localparam int          MEM_DEPTH   = 64;
	localparam int          AP_BIT      = 8;
	localparam int          COL_HI_BIT  = 9;
	localparam logic [2:0]  BURST_LEN   = 3'h4;
	localparam logic [2:0]  BEATS_NONE  = 3'h0;

	// Row strobe, column strobe and write enable levels for each command.
	localparam logic [2:0]  CODE_MODE   = 3'h0;
	localparam logic [2:0]  CODE_REF    = 3'h1;
	localparam logic [2:0]  CODE_PRE    = 3'h2;
	localparam logic [2:0]  CODE_ACT    = 3'h3;
	localparam logic [2:0]  CODE_WRITE  = 3'h4;
	localparam logic [2:0]  CODE_READ   = 3'h5;

	typedef struct packed {
		logic              chipSelectN;
		logic              rowStrobeN;
		logic              columnStrobeN;
		logic              writeEnableN;
		logic [1:0]        bankSelect;
		logic [ROW_W-1:0]  addr;
	} gdp_cmd_pins_t;

	typedef enum {CMD_DESELECT, CMD_NOP, CMD_ACTIVATE, CMD_READ, CMD_WRITE,
		CMD_PRECHARGE, CMD_REFRESH, CMD_MODE_SET} gdp_cmd_t;

	typedef enum {PWR_ACTIVE, PWR_PRE_PDN, PWR_ACT_PDN, PWR_SELF_REF} gdp_pwr_t;

endpackage

// ==== hdl/gdp_sync.sv ====
// Two flip-flop synchroniser for a group of asynchronous pin levels.
`timescale 1ns/1ps
module gdp_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] asyncIn,
	output logic      [W-1:0] syncOut
);
	logic [W-1:0] stage1_ff;
	logic [W-1:0] stage2_ff;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			stage1_ff <= '0;
			stage2_ff <= '0;
		end else begin
			stage1_ff <= asyncIn;
			stage2_ff <= stage1_ff;
		end
	end

	assign syncOut = stage2_ff;
endmodule

// ==== verif/gdp_ctrl_model.sv ====
// Controller-side model: link clock, command pins and write bursts.
`timescale 1ns/1ps
module gdp_ctrl_model
	import gdp_pkg::*;
(
	input  wire logic         clk,
	output logic              ckTrue,
	output logic              ckComp,
	output logic              clockEnable,
	output gdp_cmd_pins_t     cmdPins,
	output logic              mirrorReserved,
	output logic [LANES-1:0]  writeMask,
	output logic [LANES-1:0]  writeStrobe,
	output logic [DATA_W-1:0] dataIn
);
	logic ckRun;
	logic mirrorOn;
	assign ckComp = ~ckTrue;
	////////////////////////////////////////
	initial begin
		ckRun = 1'b1;
		mirrorOn = 1'b0;
		ckTrue = 1'b0;
		clockEnable = 1'b1;
		cmdPins = {1'b0, 3'h7, 14'h0};
		// A high level on the unused mirror ball must not disturb the device.
		mirrorReserved = 1'b1;
		writeMask = 4'h0;
		writeStrobe = 4'h0;
		dataIn = 32'h0;
		#11;
		// The clock only stands still while the bench parks it in self refresh.
		forever begin
			#80;
			if (ckRun) ckTrue = ~ckTrue;
		end
	end
	////////////////////////////////////////
	task automatic settle();
		@(posedge clk);
		#1;
	endtask
	// Pins change away from the sampling crossing so the device synchroniser sees them settled.
	task automatic issue(input logic [2:0] code, input logic [1:0] bank, input logic [11:0] addr,
		input logic csN, input logic cke, input bit onFall);
		if (onFall) @(posedge ckTrue);
		else @(negedge ckTrue);
		settle();
		// With the mirror strap high the row strobe travels on the reserved ball; its own ball idles high.
		cmdPins = {csN, code[2] | mirrorOn, code[1:0], bank, addr};
		mirrorReserved = code[2] | ~mirrorOn;
		clockEnable = cke;
		if (onFall) @(negedge ckTrue);
		else @(posedge ckTrue);
		repeat (3) settle();
		cmdPins = {1'b0, 3'h7, ~bank, ~addr};
		mirrorReserved = 1'b1;
	endtask
	task automatic writeBurst(input logic [DATA_W-1:0] words [4], input logic [LANES-1:0] masks [4]);
		for (int i = 0; i < 4; i++) begin
			settle();
			dataIn = words[i];
			writeMask = masks[i];
			repeat (4) settle();
			writeStrobe = ~writeStrobe;
			repeat (4) settle();
		end
		dataIn = ~dataIn;
		writeMask = ~writeMask;
	endtask
	task automatic parkClock(input logic run);
		settle();
		// Non-blocking, so a clock toggle due in the same step still sees the old setting.
		ckRun <= run;
	endtask
	task automatic setMirror(input logic on);
		mirrorOn = on;
	endtask
	task automatic setCke(input logic v);
		settle();
		clockEnable = v;
	endtask
endmodule

// ==== verif/tb.sv ====
// Self-checking bench for the graphics DRAM pin interface.
`timescale 1ns/1ps
module tb;
	import gdp_pkg::*;
	logic              clk, rst_n, ckTrue, ckComp, clockEnable;
	logic              mirrorReserved, mirrorSelect, dataOe, readStrobeOe;
	gdp_cmd_pins_t     cmdPins;
	logic [LANES-1:0]  writeMask, writeStrobe, readStrobe;
	logic [DATA_W-1:0] dataIn, dataOut;
	logic [ROW_W-1:0]  modeReg, expMode;
	gdp_pwr_t          powerState;
	logic [DATA_W-1:0] memModel [BANKS][16];
	int                mismatches, numChecks;
	gdp_ctrl_model ctrl_u (.clk, .ckTrue, .ckComp, .clockEnable, .cmdPins, .mirrorReserved, .writeMask,
		.writeStrobe, .dataIn);
	gdp_pin_interface dut_u (.clk, .rst_n, .ckTrue, .ckComp, .clockEnable, .cmdPins, .mirrorReserved,
		.mirrorSelect, .writeMask, .writeStrobe, .dataIn, .dataOut, .dataOe, .readStrobe, .readStrobeOe,
		.modeReg, .powerState);
	////////////////////////////////////////
	task automatic cmpVal(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
		numChecks++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic cmpPwr(input gdp_pwr_t got, input gdp_pwr_t exp);
		numChecks++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic summarize();
		if (mismatches == 0 && numChecks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	////////////////////////////////////////
	task automatic modeTry(input logic [2:0] code, input logic [11:0] addr, input logic csN, input bit onFall);
		ctrl_u.issue(code, 2'h0, addr, csN, 1'b1, onFall);
		#40;
		cmpVal(32'(modeReg), 32'(expMode));
	endtask
	task automatic readBurst(input logic [1:0] bank, input logic [3:0] col);
		logic [LANES-1:0] prev;
		ctrl_u.issue(CODE_READ, bank, {8'h0, col}, 1'b0, 1'b1, 1'b0);
		prev = readStrobe;
		@(ckTrue);
		#100;
		for (int i = 0; i < 5; i++) begin
			if (i > 0) #80;
			cmpVal(32'(dataOe), 32'(i < 4));
			cmpVal(32'(readStrobeOe), 32'(i < 4));
			if (i < 4) begin
				cmpVal(dataOut, memModel[bank][col + 4'(i)]);
				cmpVal(32'(readStrobe), 32'(prev ^ 4'hf));
				prev = readStrobe;
			end
		end
	endtask
	task automatic writeScenario();
		logic [DATA_W-1:0] words [4];
		logic [LANES-1:0]  masks [4];
		logic [1:0]        bank;
		logic [3:0]        col;
		ctrl_u.issue(CODE_ACT, 2'h2, 12'h5a3, 1'b0, 1'b1, 1'b0);
		for (int p = 0; p < 3; p++) begin
			bank = (p == 1) ? 2'h1 : 2'h2;
			for (int i = 0; i < 4; i++) begin
				words[i] = {4{8'(16 * p + i)}};
				masks[i] = (p == 2) ? 4'(1 << i) : 4'h0;
				col = 4'he + 4'(i);
				for (int l = 0; l < LANES; l++)
					if (!masks[i][l]) memModel[bank][col][8*l +: 8] = words[i][8*l +: 8];
			end
			// The last burst also sets auto precharge, closing bank 2 before the power checks.
			ctrl_u.issue(CODE_WRITE, bank, {3'h0, p == 2, 8'h0e}, 1'b0, 1'b1, 1'b0);
			ctrl_u.writeBurst(words, masks);
		end
		readBurst(2'h2, 4'he);
		readBurst(2'h1, 4'he);
	endtask
	task automatic pwrStep(input gdp_pwr_t exp);
		ctrl_u.issue(3'h7, 2'h0, 12'h0, 1'b0, 1'b0, 1'b0);
		#40;
		cmpPwr(powerState, exp);
		ctrl_u.issue(CODE_MODE, 2'h0, 12'h0f0, 1'b0, 1'b0, 1'b0);
		#40;
		cmpVal(32'(modeReg), 32'(expMode));
		ctrl_u.issue(3'h7, 2'h0, 12'h0, 1'b0, 1'b1, 1'b0);
		#40;
		cmpPwr(powerState, PWR_ACTIVE);
	endtask
	task automatic powerScenario();
		pwrStep(PWR_PRE_PDN);
		ctrl_u.issue(CODE_ACT, 2'h1, 12'h0ff, 1'b0, 1'b1, 1'b0);
		ctrl_u.issue(CODE_PRE, 2'h0, 12'h000, 1'b0, 1'b1, 1'b0);
		pwrStep(PWR_ACT_PDN);
		ctrl_u.issue(CODE_PRE, 2'h0, 12'h100, 1'b0, 1'b1, 1'b0);
		pwrStep(PWR_PRE_PDN);
	endtask
	task automatic selfRefScenario();
		ctrl_u.issue(CODE_REF, 2'h0, 12'h0, 1'b0, 1'b0, 1'b0);
		#40;
		cmpPwr(powerState, PWR_SELF_REF);
		ctrl_u.parkClock(1'b0);
		ctrl_u.setCke(1'b1);
		repeat (4) @(posedge clk);
		#1;
		cmpPwr(powerState, PWR_ACTIVE);
		ctrl_u.parkClock(1'b1);
		expMode = 12'h1e7;
		modeTry(CODE_MODE, 12'h1e7, 1'b0, 1'b0);
	endtask
	// A second reset with the strap high; a mode set whose row strobe rides the reserved ball must load.
	task automatic mirrorScenario();
		@(posedge clk);
		#1;
		rst_n = 1'b0;
		mirrorSelect = 1'b1;
		ctrl_u.setMirror(1'b1);
		repeat (6) @(posedge clk);
		#1;
		rst_n = 1'b1;
		repeat (3) @(posedge clk);
		#1;
		cmpVal(32'(modeReg), 32'h0);
		cmpVal(32'(dataOe), 32'h0);
		cmpPwr(powerState, PWR_ACTIVE);
		expMode = 12'h2d4;
		modeTry(CODE_MODE, 12'h2d4, 1'b0, 1'b0);
	endtask
	////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	initial begin
		#200000;
		mismatches++;
		summarize();
	end
	initial begin
		rst_n = 1'b0;
		mirrorSelect = 1'b0;
		mismatches = 0;
		numChecks = 0;
		expMode = 12'h0;
		repeat (6) @(posedge clk);
		#1;
		rst_n = 1'b1;
		repeat (3) @(posedge clk);
		#1;
		cmpPwr(powerState, PWR_ACTIVE);
		cmpVal(32'(dataOe), 32'h0);
		expMode = 12'ha5c;
		modeTry(CODE_MODE, 12'ha5c, 1'b0, 1'b0);
		modeTry(CODE_MODE, 12'h3c1, 1'b1, 1'b0);
		modeTry(CODE_MODE, 12'h3c1, 1'b0, 1'b1);
		modeTry(CODE_REF, 12'h3c1, 1'b0, 1'b0);
		writeScenario();
		powerScenario();
		selfRefScenario();
		mirrorScenario();
		summarize();
	end
endmodule
